// File: core/rmf_rate_match.sv
// Receive rate match FIFO: skip insertion and deletion on user pattern
// Functional notes
// - After alignment, look for control code followed by skip code.
// - Add or drop skips at clusters to keep buffer from running dry/over.
// - Single width: insert at most four, cluster keeps at most five skips.
// - Single width: delete at most four, always leave one skip.
// - Single width: the byte that would overfill the buffer is dropped.
// - Single width: reading an empty buffer yields code 9'h1FE.
// - Double width: insert skips only as full-word pairs.
// - Double width: delete skips only as full-word pairs.
// - Double width: skips split across cycles are never deleted.
// - Double width: the whole word that would overfill is dropped.
// - Double width: empty read yields two 9'h1FE codes in one word.
// - Work left over at one cluster carries to following clusters.
`timescale 1ns/1ns
`include "rmf_defs.svh"
module rmf_rate_match (
  // Clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              rst_n_i,
  // Recovered link side
  input  wire logic              link_clk_i,
  input  wire logic              link_sync_i,
  input  wire rmf_pkg::rmf_word_t link_data_i,
  // Configuration
  input  wire logic              double_width_i,
  input  wire logic              rm_enable_i,
  input  wire rmf_pkg::rmf_word_t pattern_i,
  // Read side
  input  wire logic              rd_req_i,
  output logic                   rd_valid_o,
  output rmf_pkg::rmf_word_t     rd_data_o,
  // Status
  output logic [`RMF_LEVEL_W-1:0] fill_level_o,
  output logic                   skip_ins_o,
  output logic                   skip_del_o,
  output logic                   full_drop_o,
  output logic                   empty_fill_o
);
  import rmf_pkg::*;

  // Link sampling
  logic [`RMF_SYNC_W-1:0] sync_in, sync_out;
  logic                   lclk_s, lsync_s;
  rmf_word_t              ldata_s;
  logic                   lclk_prev_q, lclk_prev_d;
  logic                   take;

  assign sync_in = {link_clk_i, link_sync_i, link_data_i};

  // Data and clock share the same delay, so no skew between them
  rmf_sync #(.W(`RMF_SYNC_W)) u_sync (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .async_i   (sync_in),
    .sync_o    (sync_out)
  );

  assign lclk_s  = sync_out[`RMF_SYNC_W-1];
  assign lsync_s = sync_out[`RMF_SYNC_W-2];
  assign ldata_s = sync_out[`RMF_WORD_W-1:0];

  // Falling edge is mid-eye: data launched on rising edge is settled
  assign take = lclk_prev_q && !lclk_s && lsync_s;

  // Pattern and word classification
  rmf_sym_t  ctl_sym, skp_sym, lo_sym, hi_sym;
  rmf_word_t smp_word, skip_word, empty_word;
  logic      is_ctl, is_skp;

  assign ctl_sym = pattern_i[`RMF_CTL_LSB +: `RMF_SYM_W];
  assign skp_sym = pattern_i[`RMF_SKP_LSB +: `RMF_SYM_W];
  assign lo_sym  = ldata_s[`RMF_CTL_LSB +: `RMF_SYM_W];
  assign hi_sym  = ldata_s[`RMF_SKP_LSB +: `RMF_SYM_W];

  always_comb begin
    if (double_width_i) begin
      smp_word   = ldata_s;
      skip_word  = {skp_sym, skp_sym};
      empty_word = {`RMF_EMPTY_CODE, `RMF_EMPTY_CODE};
      is_ctl     = (lo_sym == ctl_sym && hi_sym == skp_sym) ||
                   (hi_sym == ctl_sym);
      is_skp     = (lo_sym == skp_sym) && (hi_sym == skp_sym);
    end else begin
      smp_word   = {10'h000, lo_sym};
      skip_word  = {10'h000, skp_sym};
      empty_word = {10'h000, `RMF_EMPTY_CODE};
      is_ctl     = (lo_sym == ctl_sym);
      is_skp     = (lo_sym == skp_sym);
    end
  end

  // Buffer
  logic                    wr_valid, wr_ready;
  rmf_word_t               wr_data;
  logic                    ff_valid, pop;
  rmf_word_t               ff_data;
  logic [`RMF_LEVEL_W-1:0] level;
  logic                    del_req, ins_req;

  rmf_fifo #(.W(`RMF_WORD_W), .DEPTH(`RMF_DEPTH)) u_fifo (
    .clk_sys_i   (clk_sys_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (wr_valid),
    .in_ready_o  (wr_ready),
    .in_data_i   (wr_data),
    .out_valid_o (ff_valid),
    .out_ready_i (pop),
    .out_data_o  (ff_data),
    .level_o     (level)
  );

  assign del_req = rm_enable_i && (level > `RMF_HI_MARK);
  assign ins_req = rm_enable_i && (level < `RMF_LO_MARK);

  // Write side state
  rmf_wr_state_t st_q, st_d;
  logic          in_clu_q, in_clu_d;
  logic [2:0]    kept_q, kept_d;
  logic [2:0]    del_cnt_q, del_cnt_d;
  logic [2:0]    ins_cnt_q, ins_cnt_d;
  rmf_word_t     pend_q, pend_d;
  logic          can_del, can_ins, del_ev, ins_ev, drop_ev;
  logic [3:0]    skips_after;

  assign skips_after = {1'b0, kept_q} + {1'b0, ins_cnt_q};

  // Limits are per cluster; unmet demand waits for the next one
  assign can_del = del_req && (double_width_i ||
                   (kept_q != `RMF_CNT_RST &&
                    del_cnt_q < `RMF_MAX_DEL));
  assign can_ins = ins_req && ins_cnt_q < `RMF_MAX_INS &&
                   (double_width_i || (kept_q != `RMF_CNT_RST &&
                    skips_after < `RMF_MAX_SKIPS));

  always_comb begin
    st_d        = st_q;
    in_clu_d    = in_clu_q;
    kept_d      = kept_q;
    del_cnt_d   = del_cnt_q;
    ins_cnt_d   = ins_cnt_q;
    pend_d      = pend_q;
    lclk_prev_d = lclk_s;
    wr_valid    = 1'b0;
    wr_data     = smp_word;
    del_ev      = 1'b0;
    ins_ev      = 1'b0;
    unique case (st_q)
      WR_PASS: begin
        if (take && is_ctl) begin
          wr_valid  = 1'b1;
          in_clu_d  = 1'b1;
          kept_d    = `RMF_CNT_RST;
          del_cnt_d = `RMF_CNT_RST;
          ins_cnt_d = `RMF_CNT_RST;
        end else if (take && in_clu_q && is_skp) begin
          if (can_del) begin
            del_ev    = 1'b1;
            del_cnt_d = del_cnt_q + 3'd1;
          end else begin
            wr_valid = 1'b1;
            kept_d   = (kept_q == 3'd7) ? kept_q : kept_q + 3'd1;
          end
        end else if (take) begin
          in_clu_d = 1'b0;
          if (in_clu_q && can_ins) begin
            st_d   = WR_INSERT;
            pend_d = smp_word;
          end else begin
            wr_valid = 1'b1;
          end
        end
      end
      WR_INSERT: begin
        wr_valid = 1'b1;
        if (can_ins) begin
          wr_data   = skip_word;
          ins_ev    = 1'b1;
          ins_cnt_d = ins_cnt_q + 3'd1;
        end else begin
          wr_data = pend_q;
          st_d    = WR_PASS;
        end
      end
    endcase
  end

  // A word the buffer cannot take is lost whole
  assign drop_ev = wr_valid && !wr_ready;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q        <= WR_PASS;
      in_clu_q    <= 1'b0;
      kept_q      <= `RMF_CNT_RST;
      del_cnt_q   <= `RMF_CNT_RST;
      ins_cnt_q   <= `RMF_CNT_RST;
      pend_q      <= `RMF_WORD_RST;
      lclk_prev_q <= 1'b0;
    end else begin
      st_q        <= st_d;
      in_clu_q    <= in_clu_d;
      kept_q      <= kept_d;
      del_cnt_q   <= del_cnt_d;
      ins_cnt_q   <= ins_cnt_d;
      pend_q      <= pend_d;
      lclk_prev_q <= lclk_prev_d;
    end
  end

  // Read side and status
  rmf_word_t rd_data_q, rd_data_d;
  logic      rd_valid_q, rd_valid_d;
  logic      efill_q, efill_d;
  logic      ins_q, del_q, drop_q;

  always_comb begin
    rd_data_d  = rd_data_q;
    rd_valid_d = rd_req_i;
    efill_d    = 1'b0;
    pop        = 1'b0;
    if (rd_req_i && ff_valid) begin
      pop       = 1'b1;
      rd_data_d = ff_data;
    end else if (rd_req_i) begin
      efill_d   = 1'b1;
      rd_data_d = empty_word;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_q  <= `RMF_WORD_RST;
      rd_valid_q <= 1'b0;
      efill_q    <= 1'b0;
      ins_q      <= 1'b0;
      del_q      <= 1'b0;
      drop_q     <= 1'b0;
    end else begin
      rd_data_q  <= rd_data_d;
      rd_valid_q <= rd_valid_d;
      efill_q    <= efill_d;
      ins_q      <= ins_ev && wr_ready;
      del_q      <= del_ev;
      drop_q     <= drop_ev;
    end
  end

  assign rd_valid_o   = rd_valid_q;
  assign rd_data_o    = rd_data_q;
  assign empty_fill_o = efill_q;
  assign skip_ins_o   = ins_q;
  assign skip_del_o   = del_q;
  assign full_drop_o  = drop_q;
  assign fill_level_o = level;

  // Checks
  clu_start_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (st_q == WR_PASS && take && is_ctl) |=> (in_clu_q && kept_q == 3'd0))
    else $error("cluster not opened on control code");

  del_keep_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (del_ev && !double_width_i) |-> (kept_q >= 3'd1 && del_cnt_q <= 3'd3))
    else $error("single width deletion broke cluster limits");

  ins_limit_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (ins_ev && !double_width_i) |-> (skips_after <= 4'd4 &&
                                     ins_cnt_q <= 3'd3))
    else $error("single width insertion broke cluster limits");

  full_drop_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (wr_valid && level == 5'd16) |=> full_drop_o)
    else $error("write into full buffer not reported as dropped");

  empty_fill_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (rd_req_i && level == 5'd0 && !double_width_i) |=>
      (rd_valid_o && empty_fill_o && rd_data_o == 20'h001fe))
    else $error("single width empty read without filler code");

  empty_pair_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (rd_req_i && level == 5'd0 && double_width_i) |=>
      (rd_valid_o && rd_data_o == 20'h7f9fe))
    else $error("double width empty read without filler pair");

  dw_del_pair_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (del_ev && double_width_i) |-> (lo_sym == skp_sym && hi_sym == skp_sym))
    else $error("double width deleted a split skip word");

  dw_ins_pair_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (ins_ev && double_width_i) |-> (wr_data == {skp_sym, skp_sym}))
    else $error("double width inserted a partial skip word");

  rm_gate_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (del_ev || ins_ev) |-> (rm_enable_i &&
      (del_ev ? level > 5'd11 : level < 5'd5)))
    else $error("skip change outside fill marks or while disabled");

  insert_end_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (st_q == WR_PASS ##1 st_q == WR_INSERT) |-> ##[1:5] (st_q == WR_PASS))
    else $error("insertion burst did not finish in time");

endmodule // rmf_rate_match

// File: include/rmf_defs.svh
// Constants for the receive rate match FIFO
`ifndef RMF_DEFS_SVH
`define RMF_DEFS_SVH

// Buffer shape
`define RMF_WORD_W     20
`define RMF_DEPTH      16
`define RMF_LEVEL_W    5

// Fill marks steering insertion and deletion
`define RMF_HI_MARK    5'd11
`define RMF_LO_MARK    5'd5

// Per-cluster limits; RMF_MAX_DEL and RMF_MAX_SKIPS apply in single-width mode only, RMF_MAX_INS in both modes
`define RMF_MAX_INS    3'd4
`define RMF_MAX_DEL    3'd4
`define RMF_MAX_SKIPS  4'd5

// Filler code sent while the buffer is empty
`define RMF_EMPTY_CODE 10'h1fe

// Field positions inside the user pattern and a data word
`define RMF_CTL_LSB    0
`define RMF_SKP_LSB    10
`define RMF_SYM_W      10

// Synchroniser width of the link group
`define RMF_SYNC_W     22

// Reset values
`define RMF_WORD_RST   20'h00000
`define RMF_CNT_RST    3'h0

`endif

// File: include/rmf_pkg.sv
// Types shared by the rate match FIFO modules
package rmf_pkg;

  typedef logic [19:0] rmf_word_t;
  typedef logic [9:0]  rmf_sym_t;

  typedef enum logic [0:0] {
    WR_PASS   = 1'b0,
    WR_INSERT = 1'b1
  } rmf_wr_state_t;

endpackage

// File: core/rmf_sync.sv
// Two-flop synchroniser for signals entering the system clock domain
`timescale 1ns/1ns
module rmf_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_sys_i,
  input  wire logic         rst_n_i,
  // Asynchronous in, synchronised out
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule // rmf_sync

// File: core/rmf_fifo.sv
// Flip-flop FIFO with valid/ready on both sides and a fill level
`timescale 1ns/1ns
module rmf_fifo #(
  parameter int W     = 20,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic                       clk_sys_i,
  input  wire logic                       rst_n_i,
  // Fill side
  input  wire logic                       in_valid_i,
  output logic                            in_ready_o,
  input  wire logic [W-1:0]               in_data_i,
  // Drain side
  output logic                            out_valid_o,
  input  wire logic                       out_ready_i,
  output logic      [W-1:0]               out_data_o,
  // Status
  output logic      [$clog2(DEPTH):0]     level_o
);

  localparam int PW = $clog2(DEPTH);

  logic [W-1:0]  mem_q [DEPTH];
  logic [PW-1:0] wr_ptr_q, wr_ptr_d;
  logic [PW-1:0] rd_ptr_q, rd_ptr_d;
  logic [PW:0]   cnt_q, cnt_d;
  logic          push, pop;

  assign in_ready_o  = (cnt_q != (PW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rd_ptr_q];
  assign level_o     = cnt_q;

  always_comb begin
    push     = in_valid_i && in_ready_o;
    pop      = out_valid_o && out_ready_i;
    wr_ptr_d = push ? wr_ptr_q + 1'b1 : wr_ptr_q;
    rd_ptr_d = pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
    cnt_d    = cnt_q + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q    <= '0;
    end else begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      cnt_q    <= cnt_d;
    end
  end

  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        mem_q[i] <= '0;
      end else if (push && wr_ptr_q == PW'(i)) begin
        mem_q[i] <= in_data_i;
      end
    end
  end

  fifo_bound_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    cnt_q <= (PW+1)'(DEPTH))
    else $error("fifo level above depth");

endmodule // rmf_fifo

// File: testbench/rmf_link_model.sv
// Behavioural upstream link transmitter feeding the recovered side
`timescale 1ns/1ns
module rmf_link_model (
  // Recovered link outputs
  output logic               link_clk_o,
  output logic               link_sync_o,
  output rmf_pkg::rmf_word_t link_data_o
);
  import rmf_pkg::*;

  // Clock stands still low between words, it never runs free
  initial begin
    link_clk_o  = 1'b0;
    link_sync_o = 1'b0;
    link_data_o = 20'h00000;
  end

  // One coded word per 400 ns period, launched on the rising edge
  task automatic send(input rmf_word_t w);
    link_data_o = w;
    link_clk_o  = 1'b1;
    #200;
    link_clk_o  = 1'b0;
    #100;
    // Past the hold time the line no longer shows the word
    link_data_o = ~w;
    #100;
  endtask

  task automatic set_sync(input logic s);
    link_sync_o = s;
  endtask
endmodule // rmf_link_model

// File: testbench/test_rmf_rate_match.sv
// Self-checking bench for the receive rate match FIFO
`timescale 1ns/1ns
`include "rmf_defs.svh"
module test_rmf_rate_match;
  import rmf_pkg::*;

  localparam rmf_sym_t CTL = 10'h17c;
  localparam rmf_sym_t SKP = 10'h0f4;

  logic                    clk_sys_i      = 1'b0;
  logic                    rst_n_i        = 1'b0;
  logic                    double_width_i = 1'b0;
  logic                    rm_enable_i    = 1'b0;
  logic                    rd_req_i       = 1'b0;
  logic                    link_clk;
  logic                    link_sync;
  rmf_word_t               link_data;
  rmf_word_t               pattern;
  logic                    rd_valid_o;
  rmf_word_t               rd_data_o;
  logic [`RMF_LEVEL_W-1:0] fill_level_o;
  logic                    skip_ins_o;
  logic                    skip_del_o;
  logic                    full_drop_o;
  logic                    empty_fill_o;
  int                      err_total = 0;
  int                      cmp_count = 0;
  int                      n_ins;
  int                      n_del;
  int                      n_drop;
  rmf_word_t               rd_w;
  logic                    rd_f;

  assign pattern = {SKP, CTL};

  always #25 clk_sys_i = ~clk_sys_i;

  rmf_link_model lnk (
    .link_clk_o  (link_clk),
    .link_sync_o (link_sync),
    .link_data_o (link_data)
  );

  rmf_rate_match uut (
    .clk_sys_i      (clk_sys_i),
    .rst_n_i        (rst_n_i),
    .link_clk_i     (link_clk),
    .link_sync_i    (link_sync),
    .link_data_i    (link_data),
    .double_width_i (double_width_i),
    .rm_enable_i    (rm_enable_i),
    .pattern_i      (pattern),
    .rd_req_i       (rd_req_i),
    .rd_valid_o     (rd_valid_o),
    .rd_data_o      (rd_data_o),
    .fill_level_o   (fill_level_o),
    .skip_ins_o     (skip_ins_o),
    .skip_del_o     (skip_del_o),
    .full_drop_o    (full_drop_o),
    .empty_fill_o   (empty_fill_o)
  );

  // Status pulses last one cycle, so they are counted at every edge
  always @(posedge clk_sys_i) begin
    if (skip_ins_o === 1'b1) n_ins++;
    if (skip_del_o === 1'b1) n_del++;
    if (full_drop_o === 1'b1) n_drop++;
  end

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input rmf_word_t seen,
                     input rmf_word_t exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  // Data words avoid both pattern symbols
  function automatic rmf_word_t mk(input logic m, input int i);
    return m ? {10'h080 + 10'(i), 10'h0a0 + 10'(i)}
             : {10'h000, 10'h0a0 + 10'(i)};
  endfunction

  // Stream with clusters at low and at high fill
  function automatic rmf_word_t pk(input logic m, input int i);
    if (i == 1 || i == 12) return m ? {SKP, CTL} : {10'h000, CTL};
    if (i == 2 || i == 3 || i == 13 || i == 14)
      return m ? {SKP, SKP} : {10'h000, SKP};
    return mk(m, i);
  endfunction

  // Answer comes exactly one cycle after the request edge
  task automatic rd_one();
    rd_req_i = 1'b1;
    tick(1);
    rd_req_i = 1'b0;
    chk("rd_valid", 20'(rd_valid_o), 20'h1);
    rd_w = rd_data_o;
    rd_f = empty_fill_o;
    // Idle cycle keeps request edges apart
    tick(1);
  endtask

  task automatic rd_cnt(input int n, input rmf_word_t match, output int c);
    c = 0;
    for (int i = 0; i < n; i++) begin
      rd_one();
      if (rd_w === match) c++;
    end
    chk("level drained", 20'(fill_level_o), 20'h0);
  endtask

  task automatic t_full(input logic m);
    double_width_i = m;
    rm_enable_i = 1'b0;
    n_ins = 0;
    n_del = 0;
    n_drop = 0;
    for (int i = 0; i < 17; i++) lnk.send(pk(m, i));
    tick(8);
    chk("level full", 20'(fill_level_o), 20'h10);
    chk("drops", 20'(n_drop), 20'h1);
    chk("ins del off", 20'(n_ins + n_del), 20'h0);
    for (int i = 0; i < 16; i++) begin
      rd_one();
      chk("full data", rd_w, pk(m, i));
    end
    rd_one();
    chk("empty code", rd_w, m ? {10'h1fe, 10'h1fe} : 20'h001fe);
    chk("empty flag", 20'(rd_f), 20'h1);
    rm_enable_i = 1'b1;
  endtask

  task automatic t_del_s();
    int sk;
    double_width_i = 1'b0;
    n_del = 0;
    for (int i = 0; i < 12; i++) lnk.send(mk(1'b0, i));
    lnk.send({10'h000, CTL});
    repeat (6) lnk.send({10'h000, SKP});
    lnk.send(mk(1'b0, 20));
    tick(8);
    chk("del count", 20'(n_del), 20'h4);
    chk("level", 20'(fill_level_o), 20'h10);
    rd_cnt(16, {10'h000, SKP}, sk);
    chk("skips kept", 20'(sk), 20'h2);
  endtask

  task automatic t_del_d();
    int sk;
    double_width_i = 1'b1;
    n_del = 0;
    for (int i = 0; i < 12; i++) lnk.send(mk(1'b1, i));
    // Skips of this cluster fall in two different words
    lnk.send({SKP, CTL});
    lnk.send({10'h0a5, SKP});
    lnk.send({SKP, CTL});
    repeat (2) lnk.send({SKP, SKP});
    lnk.send(mk(1'b1, 20));
    tick(8);
    chk("del pairs", 20'(n_del), 20'h2);
    chk("level", 20'(fill_level_o), 20'h10);
    rd_cnt(16, {SKP, SKP}, sk);
    chk("pairs left", 20'(sk), 20'h0);
  endtask

  task automatic t_ins(input logic m, input int k);
    int lim;
    int ins;
    rmf_word_t c;
    rmf_word_t s;
    double_width_i = m;
    c = m ? {SKP, CTL} : {10'h000, CTL};
    s = m ? {SKP, SKP} : {10'h000, SKP};
    // Single width cluster may hold five skips at most
    lim = (m || k < 2) ? 4 : 5 - k;
    n_ins = 0;
    lnk.send(c);
    repeat (k) lnk.send(s);
    lnk.send(mk(m, 7));
    tick(8);
    ins = n_ins;
    chk("ins count", 20'(ins >= 1 && ins <= lim), 20'h1);
    rd_one();
    chk("cluster head", rd_w, c);
    for (int i = 0; i < k + ins; i++) begin
      rd_one();
      chk("skip unit", rd_w, s);
    end
    rd_one();
    chk("held word", rd_w, mk(m, 7));
    chk("level", 20'(fill_level_o), 20'h0);
  endtask

  initial begin
    tick(20);
    rst_n_i = 1'b1;
    tick(2);
    chk("reset valid", 20'(rd_valid_o), 20'h0);
    chk("reset level", 20'(fill_level_o), 20'h0);
    lnk.set_sync(1'b1);
    t_full(1'b0);
    t_full(1'b1);
    t_del_s();
    t_del_d();
    t_ins(1'b0, 3);
    t_ins(1'b0, 1);
    t_ins(1'b1, 1);
    wrap_up();
  end

  // A hang counts as a mismatch and ends in the report
  initial begin
    #2000000;
    err_total++;
    $display("FAIL watchdog expected done seen hung");
    wrap_up();
  end
endmodule // test_rmf_rate_match
